// *** verilog/cbadc_result_logic.sv ***
// Converter back end top: window sequencing, offset, scaling and register port
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
module cbadc_result_logic
  import cbadc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [DATA_W-1:0]      o_rdata,
  input  wire logic [N_CH-1:0]   i_mod_pulse,
  input  wire logic              i_external_trigger,
  output logic [2:0]             o_ref_sel,
  output logic                   o_integrating,
  output logic                   o_conv_done
);
  cbadc_mode_t      mode;
  cbadc_state_t     state_reg;
  cbadc_state_t     state_next;
  logic [7:0]       config_low_reg;
  logic [7:0]       config_high_reg;
  logic [7:0]       option_reg;
  logic [7:0]       stop_edges_reg;
  logic [2:0]       ctrl_reg;
  logic [WIN_W-1:0] win_cnt_reg;
  logic [WIN_W-1:0] win_count_reg;
  logic [WIN_W-1:0] off_wide;
  logic [7:0]       edge_cnt_reg;
  logic [7:0]       edges_eff;
  logic             trig_prev_reg;
  logic             done_reg;
  logic [2:0]       ref_sel_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rd_mux;
  logic [RES_W-1:0] result [N_CH];
  logic [3:0]       t_eff;
  logic [1:0]       off_sel;
  logic             go_req;
  logic             start_go;
  logic             trig_fall;
  logic             trigger_start_stop_mode_stop;
  logic             win_end;
  logic             measure_en;
  logic             storing;

  cbadc_acc_if acc_bus ();

  assign mode       = cbadc_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  assign t_eff      = cbadc_t_eff(config_low_reg[CFGL_T_LSB +: 4]);
  assign off_sel    = option_reg[OPT_OFF_LSB +: 2];
  assign measure_en = config_high_reg[CFGH_MEAS_BIT];
  assign storing    = (state_reg == st_store);
  assign go_req     = i_wr && (i_addr == ADDR_CTRL) && i_wdata[CTRL_GO_BIT];
  assign trig_fall  = trig_prev_reg && !i_external_trigger;
  assign edges_eff  = (stop_edges_reg == 8'h00) ? 8'h01 : stop_edges_reg;

  // Register writes; reserved bits are masked so they read back as zero
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      config_low_reg  <= CONFIG_LOW_RST;
      config_high_reg <= CONFIG_HIGH_RST;
      option_reg      <= OPTION_RST;
      stop_edges_reg  <= STOP_EDGES_RST;
      ctrl_reg        <= CTRL_RST;
    end
    else if (i_wr)
    begin
      case (i_addr)
        ADDR_CONFIG_LOW:  config_low_reg  <= i_wdata[7:0] & CONFIG_LOW_MASK;
        ADDR_CONFIG_HIGH: config_high_reg <= i_wdata[7:0] & CONFIG_HIGH_MASK;
        ADDR_OPTION:      option_reg      <= i_wdata[7:0] & OPTION_MASK;
        ADDR_STOP_EDGES:  stop_edges_reg  <= i_wdata[7:0];
        ADDR_CTRL:        ctrl_reg        <= i_wdata[2:0];
        default:          ;
      endcase
    end
  end

  // Reference selector is registered so the analog side never sees decode glitches
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      ref_sel_reg <= 3'h0;
    else if (config_low_reg[CFGL_R_LSB + 2])
      ref_sel_reg <= REF_MAX;
    else
      ref_sel_reg <= {1'b0, config_low_reg[CFGL_R_LSB +: 2]};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      trig_prev_reg <= 1'b1;
    else
      trig_prev_reg <= i_external_trigger;
  end

  // Start source per mode; requests while busy are dropped, not queued
  always_comb
  begin
    case (mode)
      free_running_mode:       start_go = ctrl_reg[CTRL_RUN_BIT];
      trigger_start_mode:      start_go = trig_fall;
      trigger_start_stop_mode: start_go = trig_fall;
      default:                 start_go = go_req;
    endcase
    if (state_reg != st_idle)
      start_go = 1'b0;
  end

  assign trigger_start_stop_mode_stop = trig_fall && (({1'b0, edge_cnt_reg} + 9'h001) >= {1'b0, edges_eff});

  always_comb
  begin
    if (mode == trigger_start_stop_mode)
      win_end = trigger_start_stop_mode_stop;
    else
      win_end = (win_cnt_reg == (cbadc_win_len(t_eff) - 24'h000001));
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      st_idle:
        if (start_go)
          state_next = st_run;
      st_run:
        if (win_end)
          state_next = st_store;
      st_store:
        state_next = st_idle;
      default:
        state_next = st_idle;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      state_reg <= st_idle;
    else
      state_reg <= state_next;
  end

  // Window clock counter; saturates so a very long external window cannot wrap
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      win_cnt_reg <= '0;
    else if (start_go)
      win_cnt_reg <= '0;
    else if ((state_reg == st_run) && (win_cnt_reg != '1))
      win_cnt_reg <= win_cnt_reg + 24'h000001;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      edge_cnt_reg <= 8'h00;
    else if (start_go)
      edge_cnt_reg <= 8'h00;
    else if ((state_reg == st_run) && trig_fall && (edge_cnt_reg != 8'hFF))
      edge_cnt_reg <= edge_cnt_reg + 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      win_count_reg <= '0;
    else if (storing)
      win_count_reg <= measure_en ? win_cnt_reg : '0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      done_reg <= 1'b0;
    else if (storing)
      done_reg <= 1'b1;
    else if (start_go)
      done_reg <= 1'b0;
  end

  // Offset is added in hardware and left for the host to remove
  always_comb
  begin
    off_wide = '0;
    if (mode == trigger_start_stop_mode)
    begin
      case (off_sel)
        2'h1:    off_wide = win_cnt_reg >> OFF_SH1;
        2'h2:    off_wide = win_cnt_reg >> OFF_SH2;
        2'h3:    off_wide = win_cnt_reg >> OFF_SH3;
        default: off_wide = '0;
      endcase
    end
    else
    begin
      case (off_sel)
        2'h1:    off_wide = {8'h00, OFF_INT1};
        2'h2:    off_wide = {8'h00, OFF_INT2};
        2'h3:    off_wide = {8'h00, OFF_INT3};
        default: off_wide = '0;
      endcase
    end
    acc_bus.offset = (|off_wide[WIN_W-1:RES_W]) ? {RES_W{1'b1}} : off_wide[RES_W-1:0];
  end

  always_comb
  begin
    if ((mode != trigger_start_stop_mode) && (t_eff > T_KEEP16))
      acc_bus.trunc_sh = t_eff - T_KEEP16;
    else
      acc_bus.trunc_sh = 4'h0;
  end

  assign acc_bus.clear    = start_go;
  assign acc_bus.count_en = (state_reg == st_run);
  assign acc_bus.store    = storing;
  assign acc_bus.div_en   = config_high_reg[CFGH_DIV_BIT];
  assign acc_bus.div_sh   = {1'b0, config_high_reg[CFGH_DSEL_LSB +: 2]} + 3'h1;

  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++)
    begin : g_chan
      cbadc_chan_acc u_acc
      (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_pulse  (i_mod_pulse[ch]),
        .acc      (acc_bus.chan),
        .o_result (result[ch])
      );
    end
  endgenerate

  always_comb
  begin
    rd_mux = '0;
    if (i_addr[3:2] == RES_PAGE)
      rd_mux[RES_W-1:0] = result[i_addr[1:0]];
    else
    begin
      case (i_addr)
        ADDR_CONFIG_LOW:  rd_mux[7:0] = config_low_reg;
        ADDR_CONFIG_HIGH: rd_mux[7:0] = config_high_reg;
        ADDR_OPTION:      rd_mux[7:0] = option_reg;
        ADDR_STOP_EDGES:  rd_mux[7:0] = stop_edges_reg;
        ADDR_CTRL:        rd_mux[2:0] = ctrl_reg;
        ADDR_STATUS:      rd_mux[1:0] = {done_reg, (state_reg != st_idle)};
        ADDR_WIN:         rd_mux[WIN_W-1:0] = win_count_reg;
        default:          rd_mux = '0;
      endcase
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      rdata_reg <= '0;
    else
      rdata_reg <= i_rd ? rd_mux : '0;
  end

  assign o_rdata       = rdata_reg;
  assign o_ref_sel     = ref_sel_reg;
  assign o_integrating = (state_reg == st_run);
  assign o_conv_done   = done_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  win_len_a: assert property (storing && mode != trigger_start_stop_mode
                              |-> win_cnt_reg == cbadc_win_len(t_eff))
    else $error("internal window length wrong");
  code_top_a: assert property (config_low_reg[3:0] == 4'hA && mode != trigger_start_stop_mode
                               && storing |-> win_cnt_reg == 24'h100000)
    else $error("longest window not 1048576 clocks");
  keep16_a: assert property (mode != trigger_start_stop_mode && t_eff == T_MAX
                             |-> acc_bus.trunc_sh == 4'h4)
    else $error("truncation shift wrong");
  ref_top_a: assert property (config_low_reg[6] |=> o_ref_sel == REF_MAX)
    else $error("largest reference not selected");
  edge_only_a: assert property (state_reg == st_run && mode == trigger_start_stop_mode && !trig_fall
                                |=> state_reg != st_store)
    else $error("external window ended without an edge");
  stop_edge_a: assert property (state_reg == st_run && mode == trigger_start_stop_mode && trig_fall
                                && edge_cnt_reg == edges_eff - 8'h01 |=> storing ##1 o_conv_done)
    else $error("stop edge did not end window");
  win_meas_a: assert property (storing && measure_en |=> win_count_reg == $past(win_cnt_reg))
    else $error("window count not stored");
  win_off_a: assert property (storing && !measure_en |=> win_count_reg == '0)
    else $error("window count stored while disabled");
  off_none_a: assert property (off_sel == 2'h0 |-> acc_bus.offset == '0)
    else $error("offset added while disabled");
  off_int_a: assert property (mode != trigger_start_stop_mode && off_sel == 2'h3
                              |-> acc_bus.offset == 16'h003F)
    else $error("internal offset wrong");
  off_trigger_start_stop_mode_a: assert property (mode == trigger_start_stop_mode && off_sel == 2'h1
                               && win_cnt_reg < 24'h100000 |-> acc_bus.offset == {3'h0, win_cnt_reg[19:7]})
    else $error("window offset wrong");
  done_rise_a: assert property (storing |=> $rose(o_conv_done))
    else $error("done did not rise at store");
  clear_start_a: assert property (acc_bus.clear |=> o_integrating && win_cnt_reg == '0 && !o_conv_done)
    else $error("window not restarted cleanly");

  free_cov_c: cover property (storing && mode == free_running_mode ##1 state_reg == st_run);
  cmd_cov_c: cover property (go_req && mode == mode_cmd ##1 o_integrating);
  trigger_start_stop_mode_cov_c: cover property (storing && mode == trigger_start_stop_mode && edges_eff > 8'h01);
  meas_cov_c: cover property (storing && measure_en && acc_bus.div_en && off_sel != 2'h0);
endmodule // cbadc_result_logic

// *** shared/cbadc_pkg.sv ***
// Constants, types and register map of the charge balance converter back end
// Contract
// - Count modulator pulses per channel in a counter up to 20 bits over the window
// - In command, free running and trigger start modes the window is a clock count
// - Integration code bits 3..0 of config low pick 1024 clocks doubled per step
// - Resolution is ten plus code; above code 6 only 16 top bits are kept
// - Reference gain bits 6..4 pick the reference; any 1XX code picks the largest
// - In trigger start-stop mode the code is ignored; trigger edges set the window
// - In trigger start-stop mode full scale equals the window clock count
// - With window measure enabled, clocks over the window are counted too
// - Offset is added only when the two-bit offset select is nonzero
// - Internally timed offsets are 0, 15, 31 or 63 counts
// - Trigger start-stop offset is window clocks shifted right by 7, 11 or 15
// - With the scaler on, the result is divided by 2, 4, 8 or 16 before storing
// - Window measure enable sits in config high; its count is stored with results
// - Each channel result is 16 bits, the window clock count 24 bits
// - A rising edge of conversion done marks each conversion end
// - In trigger start-stop mode the stop edge count picks the ending falling edge
package cbadc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_CH   = 4;
  localparam int unsigned ACC_W  = 20;
  localparam int unsigned RES_W  = 16;
  localparam int unsigned WIN_W  = 24;

  localparam logic [3:0] ADDR_CONFIG_LOW  = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_HIGH = 4'h1;
  localparam logic [3:0] ADDR_OPTION      = 4'h2;
  localparam logic [3:0] ADDR_STOP_EDGES  = 4'h3;
  localparam logic [3:0] ADDR_CTRL        = 4'h4;
  localparam logic [3:0] ADDR_STATUS      = 4'h5;
  localparam logic [1:0] RES_PAGE         = 2'h2;
  localparam logic [3:0] ADDR_WIN         = 4'hC;

  localparam logic [7:0] CONFIG_LOW_MASK  = 8'h7F;
  localparam logic [7:0] CONFIG_HIGH_MASK = 8'h0F;
  localparam logic [7:0] OPTION_MASK      = 8'h03;
  localparam logic [7:0] CONFIG_LOW_RST   = 8'h00;
  localparam logic [7:0] CONFIG_HIGH_RST  = 8'h00;
  localparam logic [7:0] OPTION_RST       = 8'h00;
  localparam logic [7:0] STOP_EDGES_RST   = 8'h01;
  localparam logic [2:0] CTRL_RST         = 3'h0;

  localparam int unsigned CFGL_T_LSB    = 0;
  localparam int unsigned CFGL_R_LSB    = 4;
  localparam int unsigned CFGH_MEAS_BIT = 0;
  localparam int unsigned CFGH_DIV_BIT  = 1;
  localparam int unsigned CFGH_DSEL_LSB = 2;
  localparam int unsigned OPT_OFF_LSB   = 0;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RUN_BIT  = 2;
  localparam int unsigned CTRL_GO_BIT   = 3;

  localparam logic [3:0]  T_MAX     = 4'hA;
  localparam logic [3:0]  T_KEEP16  = 4'h6;
  localparam logic [WIN_W-1:0] N_CLK_BASE = 24'h000400;
  localparam logic [2:0]  REF_MAX   = 3'h4;
  localparam logic [15:0] OFF_INT1  = 16'h000F;
  localparam logic [15:0] OFF_INT2  = 16'h001F;
  localparam logic [15:0] OFF_INT3  = 16'h003F;
  localparam int unsigned OFF_SH1   = 7;
  localparam int unsigned OFF_SH2   = 11;
  localparam int unsigned OFF_SH3   = 15;

  typedef enum logic [1:0] {mode_cmd, free_running_mode, trigger_start_mode,
                            trigger_start_stop_mode} cbadc_mode_t;
  typedef enum logic [1:0] {st_idle, st_run, st_store} cbadc_state_t;

  function automatic logic [3:0] cbadc_t_eff(input logic [3:0] t);
    return (t > T_MAX) ? T_MAX : t;
  endfunction

  function automatic logic [WIN_W-1:0] cbadc_win_len(input logic [3:0] t);
    return N_CLK_BASE << cbadc_t_eff(t);
  endfunction
endpackage

// *** shared/cbadc_acc_if.sv ***
// Shared control from the sequencer to the channel accumulators
`timescale 1ns/100ps
interface cbadc_acc_if;
  import cbadc_pkg::*;
  logic             clear;
  logic             count_en;
  logic             store;
  logic [3:0]       trunc_sh;
  logic [RES_W-1:0] offset;
  logic             div_en;
  logic [2:0]       div_sh;
  modport ctrl (output clear, count_en, store, trunc_sh, offset, div_en, div_sh);
  modport chan (input clear, count_en, store, trunc_sh, offset, div_en, div_sh);
endinterface

// *** verilog/cbadc_chan_acc.sv ***
// One channel: pulse counter and result post processing
`timescale 1ns/100ps
module cbadc_chan_acc
  import cbadc_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_pulse,
  cbadc_acc_if.chan              acc,
  output logic [RES_W-1:0]       o_result
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] trunc;
  logic [RES_W:0]   sum;
  logic [RES_W-1:0] sat;
  logic [RES_W-1:0] res_next;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      acc_reg <= '0;
    else if (acc.clear)
      acc_reg <= '0;
    else if (acc.count_en && i_pulse && (acc_reg != '1))
      acc_reg <= acc_reg + 20'h00001;
  end

  // Saturation keeps an overrange count from wrapping to a small value
  always_comb
  begin
    trunc = acc_reg >> acc.trunc_sh;
    sum = {1'b0, ((|trunc[ACC_W-1:RES_W]) ? {RES_W{1'b1}} : trunc[RES_W-1:0])} + {1'b0, acc.offset};
    sat = sum[RES_W] ? {RES_W{1'b1}} : sum[RES_W-1:0];
    res_next = acc.div_en ? (sat >> acc.div_sh) : sat;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_result <= '0;
    else if (acc.store)
      o_result <= res_next;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  acc_clear_a: assert property (acc.clear |=> acc_reg == '0)
    else $error("accumulator not cleared");
  acc_count_a: assert property (acc.count_en && i_pulse && !acc.clear && acc_reg < 20'h00100
                                |=> acc_reg == $past(acc_reg) + 20'h00001)
    else $error("pulse not counted");
  plain_store_a: assert property (acc.store && !acc.div_en && acc.offset == '0 && acc.trunc_sh == 4'h0
                                  && acc_reg < 20'h0FFFF |=> o_result == $past(acc_reg[RES_W-1:0]))
    else $error("plain result wrong");
  result_hold_a: assert property (!acc.store |=> $stable(o_result))
    else $error("result changed outside store");
endmodule // cbadc_chan_acc

// *** testbench/cbadc_mod_model.sv ***
// Behavioural modulator: pulse density per channel during the window
`timescale 1ns/100ps
module cbadc_mod_model
  import cbadc_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rstn,
  input  wire logic            i_integrating,
  input  wire logic            i_slow,
  output logic [N_CH-1:0]      o_pulse
);
  logic [7:0] phase_reg;
  logic       flip_reg;

  // Phase restarts with every window so the expected counts are exact
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || !i_integrating)
      phase_reg <= 8'h00;
    else
      phase_reg <= phase_reg + 8'h01;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      flip_reg <= 1'b0;
    else
      flip_reg <= ~flip_reg;
  end

  // Channel k pulses once every 2**(k+slow) cycles; outside the window the lines toggle
  // so that a counter that runs too long picks up garbage
  always_comb
  begin
    for (int k = 0; k < N_CH; k++)
    begin
      if (i_integrating)
        o_pulse[k] = (phase_reg & ((8'h01 << (k + int'(i_slow))) - 8'h01)) == 8'h00;
      else
        o_pulse[k] = flip_reg ^ k[0];
    end
  end
endmodule // cbadc_mod_model

// *** testbench/charge_balance_adc_result_logic_test.sv ***
// Self-checking bench of the converter back end
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module charge_balance_adc_result_logic_test
  import cbadc_pkg::*;
;
  logic              i_clk;
  logic              i_rstn;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic [N_CH-1:0]   i_mod_pulse;
  logic              i_external_trigger;
  logic [2:0]        o_ref_sel;
  logic              o_integrating;
  logic              o_conv_done;
  logic              slow;
  int                err_count;
  int                check_count;

  cbadc_result_logic i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_mod_pulse(i_mod_pulse), .i_external_trigger(i_external_trigger),
    .o_ref_sel(o_ref_sel), .o_integrating(o_integrating), .o_conv_done(o_conv_done));
  cbadc_mod_model i_mod (.i_clk(i_clk), .i_rstn(i_rstn), .i_integrating(o_integrating), .i_slow(slow),
    .o_pulse(i_mod_pulse));

  always #4 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d errors", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Trailing idle edge keeps a following write from reassigning i_wr in the same step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(posedge i_clk);
    d = o_rdata;
  endtask

  task automatic wait_done(output int ni, output int ne);
    ni = 0;
    ne = 0;
    do
    begin
      @(posedge i_clk);
      ne++;
      if (o_integrating === 1'b1)
        ni++;
      if (ne > 3000)
      begin
        err_count++;
        $display("[ERR] %0t conversion never ended", $time);
        end_of_test();
      end
    end
    while (o_conv_done !== 1'b1);
  endtask

  task automatic run_conv(input logic [31:0] ctrl, output int ni, output int ne);
    i_addr  <= ADDR_CTRL;
    i_wdata <= ctrl;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    wait_done(ni, ne);
  endtask

  // Falling edges exactly gap cycles apart as sampled by the block
  task automatic pulse_trig(input int gap);
    i_external_trigger <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_external_trigger <= 1'b1;
    repeat (gap - 2) @(posedge i_clk);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    for (int a = 0; a < 16; a++)
    begin
      rd(a[3:0], d);
      `CHK(d, (a == 3) ? 32'h00000001 : 32'h00000000)
    end
    wr(4'h6, 32'hFFFFFFFF);
    rd(4'h6, d);
    `CHK(d, 32'h00000000)
    wr(ADDR_CONFIG_LOW, 32'h000000FF);
    rd(ADDR_CONFIG_LOW, d);
    `CHK(d, 32'h0000007F)
    $display("test reset done");
  endtask

  task automatic t_ref();
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_CONFIG_LOW, 32'(r) << 4);
      // Selector is registered one cycle behind the register write
      @(posedge i_clk);
      `CHK(o_ref_sel, (r > 3) ? 3'h4 : 3'(r))
    end
    wr(ADDR_CONFIG_LOW, 32'h00000000);
    $display("test reference done");
  endtask

  task automatic t_offset();
    logic [31:0] d;
    logic [31:0] off;
    int          ni;
    int          ne;
    wr(ADDR_CONFIG_HIGH, 32'h00000001);
    for (int o = 0; o < 4; o++)
    begin
      off = (o == 0) ? 32'h0 : (o == 1) ? 32'h0000000F : (o == 2) ? 32'h0000001F : 32'h0000003F;
      wr(ADDR_OPTION, 32'(o));
      run_conv(32'h00000008, ni, ne);
      `CHK(ni, 1024)
      `CHK(ne, 1026)
      for (int c = 0; c < 4; c++)
      begin
        rd(4'h8 + 4'(c), d);
        `CHK(d, (32'h00000400 >> c) + off)
      end
      rd(ADDR_WIN, d);
      `CHK(d, 32'h00000400)
      rd(ADDR_STATUS, d);
      `CHK(d, 32'h00000002)
    end
    $display("test offset done");
  endtask

  task automatic t_scaler();
    logic [31:0] d;
    int          ni;
    int          ne;
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CONFIG_HIGH, 32'h00000003 | (32'(s) << 2));
      run_conv(32'h00000008, ni, ne);
      for (int c = 0; c < 4; c++)
      begin
        rd(4'h8 + 4'(c), d);
        `CHK(d, ((32'h00000400 >> c) + 32'h0000003F) >> (s + 1))
      end
    end
    wr(ADDR_CONFIG_HIGH, 32'h00000000);
    run_conv(32'h00000008, ni, ne);
    rd(ADDR_WIN, d);
    `CHK(d, 32'h00000000)
    wr(ADDR_OPTION, 32'h00000000);
    $display("test scaler done");
  endtask

  task automatic t_trig();
    logic [31:0] d;
    int          ni;
    int          ne;
    pulse_trig(10);
    rd(ADDR_STATUS, d);
    `CHK(d, 32'h00000002)
    wr(ADDR_CONFIG_LOW, 32'h00000003);
    wr(ADDR_CONFIG_HIGH, 32'h00000001);
    wr(ADDR_OPTION, 32'h00000001);
    wr(ADDR_STOP_EDGES, 32'h00000002);
    wr(ADDR_CTRL, 32'h00000003);
    slow <= 1'b1;
    pulse_trig(600);
    pulse_trig(400);
    pulse_trig(5);
    wait_done(ni, ne);
    rd(ADDR_WIN, d);
    `CHK(d, 32'h000003E8)
    // Slow modulator: channel c pulses every 2**(c+1) cycles, rounded up over 1000
    for (int c = 0; c < 4; c++)
    begin
      rd(4'h8 + 4'(c), d);
      `CHK(d, ((32'h000003E8 + (32'h2 << c) - 32'h1) >> (c + 1)) + 32'h00000007)
    end
    wr(ADDR_OPTION, 32'h00000000);
    wr(ADDR_CONFIG_LOW, 32'h00000000);
    slow <= 1'b0;
    // Trigger start: one falling edge, then an internal window of 1024 clocks
    wr(ADDR_CTRL, 32'h00000002);
    i_external_trigger <= 1'b0;
    @(posedge i_clk);
    wait_done(ni, ne);
    i_external_trigger <= 1'b1;
    `CHK(ni, 1024)
    rd(ADDR_WIN, d);
    `CHK(d, 32'h00000400)
    rd(4'h8, d);
    `CHK(d, 32'h00000400)
    wr(ADDR_CTRL, 32'h00000000);
    $display("test trigger done");
  endtask

  task automatic t_free();
    logic [31:0] d;
    int          ni;
    int          ne;
    // Free running starts one clock after the write; the second window follows the first
    wr(ADDR_CTRL, 32'h00000005);
    wait_done(ni, ne);
    `CHK(ni, 1024)
    wait_done(ni, ne);
    `CHK(ni, 1024)
    `CHK(ne, 1026)
    rd(4'h8, d);
    `CHK(d, 32'h00000400)
    wr(ADDR_CTRL, 32'h00000000);
    $display("test free running done");
  endtask

  initial
  begin
    i_clk              = 1'b0;
    i_rstn             = 1'b0;
    i_addr             = 4'h0;
    i_wdata            = 32'h0;
    i_wr               = 1'b0;
    i_rd               = 1'b0;
    i_external_trigger = 1'b1;
    slow               = 1'b0;
    err_count          = 0;
    check_count        = 0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_ref();
    t_offset();
    t_scaler();
    t_trig();
    t_free();
    end_of_test();
  end
endmodule // charge_balance_adc_result_logic_test
